// ==== hw/dmh_top.sv ====
// DMA bus master handshake with AXI4-Lite register slave
// Functional notes
// - Sample wait input in t3 only
// - Long-address mode: pin strobes upper address
// - Upper strobe floats until grant received
// - Short mode: pin is remote port request
// - Port request is actively driven output
// - Pin floats until data config written
// - Request bus when FIFO needs service
// - Reset low enters reset at once
// - No packets until start bit set
// - Reset clears command, mask, config registers (command is loaded with 8'h01 here)
// - Reset completes within ten clocks
// - Cycle is t1..t4, one wait max
// - Read/write strobes float until grant
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`include "dmh_defines.svh"
module dmh_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Local bus pins
   input  wire logic        bus_grant_in,
   input  wire logic        wait_in,
   output logic             bus_request_out,
   output logic             master_read_strobe_n_o,
   output logic             master_read_strobe_oe,
   output logic             master_write_strobe_n_o,
   output logic             master_write_strobe_oe,
   output logic             shared_pin_o,
   output logic             shared_pin_oe,
   output logic [15:0]      upper_addr_o,
   // FIFO side
   input  wire logic        fifo_service_req,
   input  wire logic        fifo_service_wr,
   output logic             fifo_cycle_done,
   output logic             nic_running
);
   // Synchronised pins
   logic grant_s;           // Grant after two flops
   logic wait_s;            // Wait after two flops

   dmh_sync u_sync_grant (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (bus_grant_in),
      .dout    (grant_s)
   );
   dmh_sync u_sync_wait (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (wait_in),
      .dout    (wait_s)
   );

   // Registers
   logic [7:0]  cmd_ff;          // Command
   logic [7:0]  dcfg_ff;         // Data configuration
   logic [7:0]  imask_ff;        // Interrupt mask
   logic [7:0]  tcfg_ff;         // Transmit configuration
   logic [15:0] rsar_lo_ff;      // Remote start address low
   logic [15:0] rsar_hi_ff;      // Remote start address high
   logic        dcfg_written_ff; // Config programmed since reset
   logic        rem_wr_ff;       // Remote direction, 1 = write
   logic [7:0]  rem_cnt_ff;      // Remote single operations left
   logic [3:0]  rst_cnt_ff;      // Reset completion counter
   logic        strobe_ff;       // Upper strobe pulse in t1
   logic        cycle_wr_ff;     // Direction of current cycle
   logic        cycle_rem_ff;    // Current cycle is remote

   // Reset is held until the counter counts down to zero, so the
   // block is fully quiet within the ten-clock budget.
   wire rst_active = !aresetn || (rst_cnt_ff != 4'h0);

   // Reset completion counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_cnt_ff <= 4'(`DMH_RESET_CYC - 2);
      end else if (rst_cnt_ff != 4'h0) begin
         rst_cnt_ff <= rst_cnt_ff - 4'h1;
      end
   end

   // Mode decode
   wire long_addr  = dcfg_ff[`DMH_DCFG_LONG_BIT];
   wire started    = cmd_ff[`DMH_CMD_START_BIT] && !rst_active;
   wire rem_pend   = (rem_cnt_ff != 8'h00) && started;

   // AXI write channel: take address and data in either order, write once both held
   logic bvalid_ff;
   logic awtaken_ff;
   logic wtaken_ff;
   logic [7:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   assign s_axi_awready = !awtaken_ff && !bvalid_ff && !rst_active;
   assign s_axi_wready  = !wtaken_ff && !bvalid_ff && !rst_active;
   wire aw_hs  = s_axi_awvalid && s_axi_awready;
   wire w_hs   = s_axi_wvalid && s_axi_wready;
   wire aw_ok  = awtaken_ff || aw_hs;
   wire w_ok   = wtaken_ff || w_hs;
   wire do_wr  = aw_ok && w_ok && !bvalid_ff;
   wire [7:0]  wr_addr = aw_hs ? s_axi_awaddr : awaddr_ff;
   wire [31:0] wr_data = w_hs ? s_axi_wdata : wdata_ff;
   wire [3:0]  wr_strb = w_hs ? s_axi_wstrb : wstrb_ff;
   wire wr_map = (wr_addr[7:5] == 3'h0) && (wr_addr[1:0] == 2'h0);

   // Write handshake state
   always_ff @(posedge aclk) begin
      if (rst_active) begin
         bvalid_ff  <= 1'b0;
         awtaken_ff <= 1'b0;
         wtaken_ff  <= 1'b0;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 32'h0;
         wstrb_ff   <= 4'h0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (aw_hs) begin
            awaddr_ff <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_wr) begin
            awtaken_ff  <= 1'b0;
            wtaken_ff   <= 1'b0;
            bvalid_ff   <= 1'b1;
            s_axi_bresp <= wr_map ? 2'h0 : 2'h2;   // Unmapped gives SLVERR
         end else begin
            awtaken_ff <= aw_ok;
            wtaken_ff  <= w_ok;
            if (s_axi_bready) begin
               bvalid_ff <= 1'b0;
            end
         end
      end
   end
   assign s_axi_bvalid = bvalid_ff;

   wire wr_cmd   = do_wr && wr_strb[0] && (wr_addr == `DMH_CMD_OFS);
   wire wr_dcfg  = do_wr && wr_strb[0] && (wr_addr == `DMH_DCFG_OFS);
   wire wr_imask = do_wr && wr_strb[0] && (wr_addr == `DMH_IMASK_OFS);
   wire wr_tcfg  = do_wr && wr_strb[0] && (wr_addr == `DMH_TCFG_OFS);
   wire wr_rlo   = do_wr && (wr_addr == `DMH_RSAR_LO_OFS);
   wire wr_rhi   = do_wr && (wr_addr == `DMH_RSAR_HI_OFS);
   wire wr_dreq  = do_wr && (wr_addr == `DMH_DMAREQ_OFS);

   // Cycle sequencer
   dmh_pkg::dmh_state_t cyc_state;
   logic cyc_busy;
   logic cyc_done;
   // FIFO service has priority over remote operations
   wire  want_cycle = (fifo_service_req && started) || rem_pend;
   wire  cyc_start  = want_cycle && !cyc_busy;

   dmh_cycle u_cycle (
      .aclk       (aclk),
      .rst_active (rst_active),
      .start      (cyc_start),
      .grant      (grant_s),
      .wait_req   (wait_s),
      .busy       (cyc_busy),
      .done       (cyc_done),
      .state      (cyc_state)
   );

   // Control registers, set to their reset values by reset (command gets 8'h01)
   always_ff @(posedge aclk) begin
      if (rst_active) begin
         cmd_ff          <= `DMH_CMD_RST;
         dcfg_ff         <= `DMH_DCFG_RST;
         imask_ff        <= `DMH_IMASK_RST;
         tcfg_ff         <= `DMH_TCFG_RST;
         dcfg_written_ff <= 1'b0;
      end else begin
         if (wr_cmd) begin
            cmd_ff <= wr_data[7:0];
         end
         if (wr_dcfg) begin
            dcfg_ff         <= wr_data[7:0];
            dcfg_written_ff <= 1'b1;
         end
         if (wr_imask) begin
            imask_ff <= wr_data[7:0];
         end
         if (wr_tcfg) begin
            tcfg_ff <= wr_data[7:0];
         end
      end
   end

   // Remote address registers; aresetn clears them, the reset counter does not
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsar_lo_ff <= 16'h0;
         rsar_hi_ff <= 16'h0;
      end else begin
         if (wr_rlo) begin
            rsar_lo_ff <= wr_data[15:0];
         end
         if (wr_rhi) begin
            rsar_hi_ff <= wr_data[15:0];
         end
      end
   end

   // Remote request count; a finishing remote cycle and a new write
   // may coincide, the write wins since it restarts the count
   always_ff @(posedge aclk) begin
      if (rst_active) begin
         rem_cnt_ff <= 8'h00;
         rem_wr_ff  <= 1'b0;
      end else if (wr_dreq) begin
         rem_cnt_ff <= wr_data[`DMH_DREQ_CNT_MSB:`DMH_DREQ_CNT_LSB];
         rem_wr_ff  <= wr_data[`DMH_DREQ_WR_BIT];
      end else if (cyc_done && cycle_rem_ff) begin
         rem_cnt_ff <= rem_cnt_ff - 8'h01;
      end
   end

   // Per-cycle attributes latched at start
   always_ff @(posedge aclk) begin
      if (rst_active) begin
         cycle_wr_ff  <= 1'b0;
         cycle_rem_ff <= 1'b0;
         strobe_ff    <= 1'b0;
      end else begin
         if (cyc_start && grant_s) begin
            cycle_rem_ff <= !(fifo_service_req && started);
            cycle_wr_ff  <= (fifo_service_req && started) ? fifo_service_wr : rem_wr_ff;
         end
         // Upper strobe high during t1 only
         strobe_ff <= (cyc_state == dmh_pkg::DMH_IDLE) && cyc_start && grant_s;
      end
   end

   // Bus request: held while work waits or a cycle runs
   logic bus_req_ff;
   always_ff @(posedge aclk) begin
      if (rst_active) begin
         bus_req_ff <= 1'b0;
      end else begin
         bus_req_ff <= want_cycle || (cyc_busy && !cyc_done);
      end
   end
   assign bus_request_out = bus_req_ff;

   // Strobes decoded in t2, t3, tw; registered, so active in t3, tw, t4
   wire in_data = (cyc_state == dmh_pkg::DMH_T2) || (cyc_state == dmh_pkg::DMH_T3)
                  || (cyc_state == dmh_pkg::DMH_TW);
   logic rd_n_ff;
   logic wr_n_ff;
   logic port_req_ff;
   always_ff @(posedge aclk) begin
      if (rst_active) begin
         rd_n_ff     <= 1'b1;
         wr_n_ff     <= 1'b1;
         port_req_ff <= 1'b0;
      end else begin
         rd_n_ff     <= !(in_data && !cycle_wr_ff);
         wr_n_ff     <= !(in_data && cycle_wr_ff);
         port_req_ff <= rem_pend && !cyc_busy;
      end
   end
   // Strobes drive only while granted; released when grant drops
   assign master_read_strobe_n_o  = rd_n_ff;
   assign master_write_strobe_n_o = wr_n_ff;
   assign master_read_strobe_oe   = grant_s;
   assign master_write_strobe_oe  = grant_s;

   // Shared pin: strobe in long mode, port request otherwise
   assign shared_pin_o  = long_addr ? strobe_ff : port_req_ff;
   // Long mode floats until grant; short mode driven once config written
   assign shared_pin_oe = dcfg_written_ff && (long_addr ? grant_s : 1'b1);

   // Upper address bits from the remote start address pair
   logic [15:0] upper_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         upper_ff <= 16'h0;
      end else begin
         // Low register gives bits 23:16, high register bits 31:24
         upper_ff <= long_addr ? {rsar_hi_ff[7:0], rsar_lo_ff[7:0]} : 16'h0;
      end
   end
   assign upper_addr_o    = upper_ff;
   assign fifo_cycle_done = cyc_done && !cycle_rem_ff;
   assign nic_running     = started;

   // Read channel
   logic rvalid_ff;
   assign s_axi_arready = !rvalid_ff && !rst_active;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire [31:0] status_w = {20'h0, rem_cnt_ff[3:0], 1'b0, cyc_state, bus_req_ff,
                           grant_s, dcfg_written_ff, cyc_busy};
   logic [31:0] rd_mux;
   logic        rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         `DMH_CMD_OFS:     rd_mux = {24'h0, cmd_ff};
         `DMH_DCFG_OFS:    rd_mux = {24'h0, dcfg_ff};
         `DMH_IMASK_OFS:   rd_mux = {24'h0, imask_ff};
         `DMH_TCFG_OFS:    rd_mux = {24'h0, tcfg_ff};
         `DMH_RSAR_LO_OFS: rd_mux = {16'h0, rsar_lo_ff};
         `DMH_RSAR_HI_OFS: rd_mux = {16'h0, rsar_hi_ff};
         `DMH_DMAREQ_OFS:  rd_mux = {16'h0, rem_cnt_ff, 7'h0, rem_wr_ff};
         `DMH_STATUS_OFS:  rd_mux = status_w;
         default: begin
            rd_mux = 32'h0;
            rd_ok  = 1'b0;
         end
      endcase
   end

   // Read data register
   always_ff @(posedge aclk) begin
      if (rst_active) begin
         rvalid_ff   <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (ar_hs) begin
         rvalid_ff   <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_ff;
endmodule : dmh_top

// ==== hw/dmh_defines.svh ====
// Constants for the DMA bus master handshake block
`ifndef DMH_DEFINES_SVH
`define DMH_DEFINES_SVH

// Register byte offsets
`define DMH_CMD_OFS       8'h00
`define DMH_DCFG_OFS      8'h04
`define DMH_IMASK_OFS     8'h08
`define DMH_TCFG_OFS      8'h0c
`define DMH_RSAR_LO_OFS   8'h10
`define DMH_RSAR_HI_OFS   8'h14
`define DMH_DMAREQ_OFS    8'h18
`define DMH_STATUS_OFS    8'h1c

// Command register fields
`define DMH_CMD_STOP_BIT  0
`define DMH_CMD_START_BIT 1
// Data configuration fields
`define DMH_DCFG_LONG_BIT 3
// DMA request register fields
`define DMH_DREQ_WR_BIT   0
`define DMH_DREQ_CNT_LSB  8
`define DMH_DREQ_CNT_MSB  15

// Reset values
`define DMH_CMD_RST       8'h01
`define DMH_DCFG_RST      8'h00
`define DMH_IMASK_RST     8'h00
`define DMH_TCFG_RST      8'h00

// Timing
`define DMH_CLK_NS        100
`define DMH_RESET_NS      1000
`define DMH_RESET_CYC     ((`DMH_RESET_NS) / (`DMH_CLK_NS))
`define DMH_CYCLE_STATES  4

`endif

// ==== hw/dmh_pkg.sv ====
// Types shared by the DMA bus master handshake block
package dmh_pkg;
   // DMA memory cycle states
   typedef enum logic [2:0] {
      DMH_IDLE,
      DMH_T1,
      DMH_T2,
      DMH_T3,
      DMH_TW,
      DMH_T4
   } dmh_state_t;
endpackage : dmh_pkg

// ==== hw/dmh_sync.sv ====
// Two-stage synchroniser for one asynchronous input
module dmh_sync (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic din,
   output logic      dout
);
   logic meta_ff;   // First stage, read only by second stage

   // Two flops in series
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= 1'b0;
         dout    <= 1'b0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule : dmh_sync

// ==== hw/dmh_cycle.sv ====
// DMA memory cycle sequencer: t1..t4 with one optional wait state
module dmh_cycle (
   input  wire logic aclk,
   input  wire logic rst_active,
   input  wire logic start,
   input  wire logic grant,
   input  wire logic wait_req,
   output logic      busy,
   output logic      done,
   output dmh_pkg::dmh_state_t state
);
   dmh_pkg::dmh_state_t nxt_state;   // Next state

   // Next-state decode
   always_comb begin
      nxt_state = state;
      unique case (state)
         dmh_pkg::DMH_IDLE: begin
            if (start && grant) begin
               nxt_state = dmh_pkg::DMH_T1;
            end
         end
         dmh_pkg::DMH_T1: nxt_state = dmh_pkg::DMH_T2;
         dmh_pkg::DMH_T2: nxt_state = dmh_pkg::DMH_T3;
         dmh_pkg::DMH_T3: begin
            // Wait sampled only here
            nxt_state = wait_req ? dmh_pkg::DMH_TW : dmh_pkg::DMH_T4;
         end
         dmh_pkg::DMH_TW: nxt_state = dmh_pkg::DMH_T4;
         dmh_pkg::DMH_T4: nxt_state = dmh_pkg::DMH_IDLE;
         default:         nxt_state = dmh_pkg::DMH_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge aclk) begin
      if (rst_active) begin
         state <= dmh_pkg::DMH_IDLE;
      end else begin
         state <= nxt_state;
      end
   end

   assign busy = (state != dmh_pkg::DMH_IDLE);
   assign done = (state == dmh_pkg::DMH_T4);
endmodule : dmh_cycle

// ==== tb/dmh_sva.sv ====
// Port checks of the DMA bus master handshake
`include "dmh_defines.svh"
module dmh_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        bus_grant_in,
   input wire logic        wait_in,
   input wire logic        bus_request_out,
   input wire logic        master_read_strobe_n_o,
   input wire logic        master_read_strobe_oe,
   input wire logic        master_write_strobe_n_o,
   input wire logic        master_write_strobe_oe,
   input wire logic        shared_pin_oe,
   input wire logic        fifo_cycle_done
);
   default clocking cb @(posedge aclk); endclocking
   // Both strobes released
   wire  idle = master_read_strobe_n_o & master_write_strobe_n_o;
   // Config write taken; assumes AW and W go together
   wire  cfg_wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready
                  & (s_axi_awaddr == `DMH_DCFG_OFS);
   logic cfg_ff; // Config written since reset
   logic long_ff; // Mode bit mirror
   // Mirror of the written mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff  <= 1'b0;
         long_ff <= 1'b0;
      end else if (cfg_wr) begin
         cfg_ff  <= 1'b1;
         long_ff <= s_axi_wdata[`DMH_DCFG_LONG_BIT];
      end
   end
   a_reset_quiet: assert property (!aresetn |=> !bus_request_out && !shared_pin_oe
      && !master_read_strobe_oe && !s_axi_bvalid) else $error("active in reset");
   a_strobe_float: assert property (disable iff (!aresetn)
      (!bus_grant_in)[*3] |-> !master_read_strobe_oe && !master_write_strobe_oe)
      else $error("strobe driven ungranted");
   a_strobe_granted: assert property (disable iff (!aresetn)
      !idle |-> master_read_strobe_oe && master_write_strobe_oe) else $error("cycle ungranted");
   a_no_wait_len: assert property (disable iff (!aresetn)
      (!wait_in)[*4] ##1 $fell(idle) |-> ##1 !idle ##1 idle) else $error("bad plain cycle");
   a_wait_len: assert property (disable iff (!aresetn)
      wait_in[*4] ##1 $fell(idle) |-> ##1 !idle ##1 !idle ##1 idle) else $error("bad wait cycle");
   a_done_edge: assert property (disable iff (!aresetn)
      fifo_cycle_done |-> !idle ##1 idle) else $error("done off t4");
   a_pin_until_cfg: assert property (disable iff (!aresetn)
      !cfg_ff |-> !shared_pin_oe) else $error("pin driven early");
   a_upper_float: assert property (disable iff (!aresetn)
      (long_ff && !bus_grant_in)[*3] |-> !shared_pin_oe) else $error("strobe pin ungranted");
   a_port_driven: assert property (disable iff (!aresetn)
      (cfg_ff && !long_ff)[*3] |-> shared_pin_oe) else $error("port request floats");
   c_wait: cover property (disable iff (!aresetn) wait_in && $fell(idle));
   c_done: cover property (disable iff (!aresetn) fifo_cycle_done);
   c_long: cover property (disable iff (!aresetn) long_ff && shared_pin_oe);
endmodule : dmh_sva

bind dmh_top dmh_sva dmh_sva_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .bus_grant_in, .wait_in, .bus_request_out, .master_read_strobe_n_o,
   .master_read_strobe_oe, .master_write_strobe_n_o, .master_write_strobe_oe,
   .shared_pin_oe, .fifo_cycle_done);

// ==== tb/dmh_arb_model.sv ====
// Arbiter and buffer memory on the far side of the local bus
module dmh_arb_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic bus_request_out,
   input  wire logic slow,
   output logic      bus_grant_in = 1'b0,
   output logic      wait_in = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_ff = 4'h0; // Grant delay count
   // Grant only answers a request, so it is never stuck high
   always @(posedge aclk) begin
      if (!aresetn || !bus_request_out) begin
         cnt_ff <= 4'h0;
         bus_grant_in <= 1'b0;
      end else if (cnt_ff >= (slow ? 4'h6 : 4'h0)) begin
         bus_grant_in <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
   // Slow memory wants a wait state on every cycle
   always @(posedge aclk) begin
      wait_in <= aresetn & slow & bus_grant_in;
   end
endmodule : dmh_arb_model

// ==== tb/testbench.sv ====
// Self-checking bench of the DMA bus master handshake
`include "dmh_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, long_mode = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic fifo_service_req = 1'b0, fifo_service_wr = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [15:0] strobe_addr = 16'h0; // Upper address seen at a strobe
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire bus_grant_in, wait_in, bus_request_out, fifo_cycle_done, nic_running;
   wire master_read_strobe_n_o, master_read_strobe_oe, shared_pin_o, shared_pin_oe;
   wire master_write_strobe_n_o, master_write_strobe_oe;
   wire [15:0] upper_addr_o;
   int failures = 0, checks = 0, dones = 0, cycles = 0;
   logic [7:0] rst_ofs [4] = '{`DMH_CMD_OFS, `DMH_DCFG_OFS, `DMH_IMASK_OFS, `DMH_TCFG_OFS};
   logic [7:0] rst_val [4] = '{`DMH_CMD_RST, `DMH_DCFG_RST, `DMH_IMASK_RST, `DMH_TCFG_RST};

   dmh_top dmh_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_grant_in, .wait_in,
      .bus_request_out, .master_read_strobe_n_o, .master_read_strobe_oe,
      .master_write_strobe_n_o, .master_write_strobe_oe, .shared_pin_o, .shared_pin_oe,
      .upper_addr_o, .fifo_service_req, .fifo_service_wr, .fifo_cycle_done, .nic_running);
   dmh_arb_model dmh_arb_model_inst (.aclk, .aresetn, .bus_request_out, .slow,
      .bus_grant_in, .wait_in);

   // 10 MHz clock
   always #50 aclk = ~aclk;
   // Cycle count, strobe capture and hang limit
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (fifo_cycle_done === 1'b1) dones <= dones + 1;
      if (long_mode && shared_pin_oe === 1'b1 && shared_pin_o === 1'b1) begin
         strobe_addr <= upper_addr_o;
      end
      if (cycles == 3000) begin
         failures = failures + 1;
         end_of_test();
      end
   end

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_data

   task automatic chk_bit(input logic got, input logic exp);
      chk_data({31'h0, got}, {31'h0, exp});
   endtask : chk_bit

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc

   // Write: AW and W offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw_p && s_axi_awready === 1'b1) begin
            aw_p = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_p && s_axi_wready === 1'b1) begin
            w_p = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk_data({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk); // An edge between transfers, so no signal is set twice at once
   endtask : axi_wr

   // Read and compare data and response
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk_data(s_axi_rdata, exp);
      chk_data({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk); // An edge between transfers, so no signal is set twice at once
   endtask : rd_chk

   task automatic reset_regs();
      for (int i = 0; i < 4; i++) rd_chk(rst_ofs[i], {24'h0, rst_val[i]}, 2'h0);
   endtask : reset_regs

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask : end_test

   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      int base;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      cyc(10);
      reset_regs();
      rd_chk(8'h40, 32'h0, 2'h2);
      axi_wr(8'h40, 32'h0, 2'h2);
      chk_bit(shared_pin_oe, 1'b0);
      chk_bit(bus_request_out, 1'b0);
      end_test("reset");
      fifo_service_req <= 1'b1;
      cyc(30);
      chk_data(32'(dones), 32'h0);
      axi_wr(`DMH_CMD_OFS, 32'h1 << `DMH_CMD_START_BIT, 2'h0);
      cyc(30);
      chk_bit(nic_running, 1'b1);
      chk_bit(bus_request_out, 1'b1);
      chk_bit(dones != 0, 1'b1);
      end_test("start");
      axi_wr(`DMH_DCFG_OFS, 32'h0, 2'h0);
      cyc(4);
      chk_bit(shared_pin_oe, 1'b1);
      base = dones;
      slow <= 1'b1;
      fifo_service_wr <= 1'b1;
      cyc(60);
      chk_bit(dones > base, 1'b1);
      fifo_service_req <= 1'b0;
      slow <= 1'b0;
      cyc(20);
      chk_bit(bus_request_out, 1'b0);
      chk_bit(master_read_strobe_oe | master_write_strobe_oe, 1'b0);
      // Two remote operations, each announced by the port request
      base = dones;
      axi_wr(`DMH_DMAREQ_OFS, (32'h2 << `DMH_DREQ_CNT_LSB) | 32'h1, 2'h0);
      chk_bit(shared_pin_o, 1'b1);
      cyc(30);
      rd_chk(`DMH_DMAREQ_OFS, 32'h1 << `DMH_DREQ_WR_BIT, 2'h0);
      chk_bit(shared_pin_o, 1'b0);
      chk_data(32'(dones - base), 32'h0);
      end_test("short mode");
      axi_wr(`DMH_RSAR_LO_OFS, 32'h34, 2'h0);
      axi_wr(`DMH_RSAR_HI_OFS, 32'h12, 2'h0);
      axi_wr(`DMH_IMASK_OFS, 32'h5a, 2'h0);
      axi_wr(`DMH_TCFG_OFS, 32'ha5, 2'h0);
      axi_wr(`DMH_DCFG_OFS, 32'h1 << `DMH_DCFG_LONG_BIT, 2'h0);
      long_mode <= 1'b1;
      cyc(4);
      chk_bit(shared_pin_oe, 1'b0);
      chk_data({16'h0, upper_addr_o}, 32'h1234);
      fifo_service_req <= 1'b1;
      cyc(30);
      chk_bit(shared_pin_oe, 1'b1);
      chk_data({16'h0, strobe_addr}, 32'h1234);
      end_test("long mode");
      aresetn <= 1'b0;
      cyc(2);
      chk_bit(bus_request_out | master_read_strobe_oe, 1'b0);
      chk_bit(shared_pin_oe, 1'b0);
      aresetn <= 1'b1;
      long_mode <= 1'b0;
      cyc(10);
      reset_regs();
      base = dones;
      cyc(30);
      chk_data(32'(dones - base), 32'h0);
      end_test("second reset");
      end_of_test();
   end
endmodule : testbench
